// *** brf_reg_file.v ***
// banked register file with pointer based addressing
// Overview of operation
// - Pointer bits 7 to 4 pick the working group used by short 4-bit addresses.
// - Pointer bits 3 to 0 pick which expanded bank is mapped into the space.
// - Short addresses reach 16 contiguous locations at the group base from the pointer.
// - Full 8-bit register addresses reach operands directly or indirectly.
// - The space 0 to 255 forms 16 groups of 16 registers per bank, 16 banks total.
// - Bank F holds only the four configuration registers; other expanded spots are absent.
// - Bank 0 holds 3 ports, 238 general registers and 15 control registers.
// - Locations e0h to efh are reached only by working or indirect addressing.
// - General registers start undefined and, except the high stack pointer at feh, keep their value over in-range resets.
// - After a low voltage reset below 1.8 V general register contents are not trusted.
// - The stack sits in general registers under the low pointer; the high one is plain storage.
// - Both stack pointers clear to zero after every reset and every stop recovery.
// - With the option built in, writes to 80h to efh are blocked while protection is on.
// - Interrupt mask bit 6 written 1 turns protection on and 0 turns it off.
// - Power on, watchdog, stop recovery and low voltage recovery each reset the block.
`include "brf_defs.vh"
module brf_reg_file #(
    parameter RAM_PROT_OPT = 1
) (
    input wire core_clk,
    input wire resetn,
    input wire por_rst,
    input wire wdt_rst,
    input wire stop_rcv_rst,
    input wire lv_rst,
    input wire acc_en,
    input wire acc_wr,
    input wire [1:0] acc_mode,
    input wire [7:0] acc_addr,
    input wire [7:0] acc_wdata,
    input wire [7:0] port_rdata,
    output reg [7:0] acc_rdata,
    output reg acc_rvalid,
    output reg [7:0] port_wdata,
    output reg [1:0] port_sel,
    output reg port_wr,
    output reg [7:0] register_group_bank_pointer,
    output reg [7:0] stack_pointer_low,
    output reg ram_protect_on,
    output reg gpr_suspect,
    output reg [7:0] port_configuration_reg,
    output reg [7:0] stop_recovery_reg,
    output reg [7:0] stop_recovery_reg_two,
    output reg [7:0] watchdog_mode_reg
);
    // ------------------------------------------------------------
    // reset gathering
    // ------------------------------------------------------------
    wire dev_rst;
    assign dev_rst = ~resetn | por_rst | wdt_rst | stop_rcv_rst | lv_rst;

    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    reg [7:0] eff_addr;
    reg direct_blocked;
    wire [3:0] grp_sel;
    wire [3:0] bank_sel;
    assign grp_sel = register_group_bank_pointer[`BRF_PTR_GRP_HI:`BRF_PTR_GRP_LO];
    assign bank_sel = register_group_bank_pointer[`BRF_PTR_BANK_HI:`BRF_PTR_BANK_LO];

    always @* begin
        eff_addr = acc_addr;
        direct_blocked = 1'b0;
        if (acc_mode == `BRF_MODE_WORK) begin
            eff_addr = {grp_sel, acc_addr[3:0]};
        end else if (acc_mode == `BRF_MODE_DIRECT) begin
            // the e0h-efh slot in an 8-bit field means working-register escape
            if (acc_addr[7:4] == `BRF_WR_HI_NIB) begin
                direct_blocked = 1'b1;
            end
            eff_addr = acc_addr;
        end else begin
            eff_addr = acc_addr;
        end
    end

    // bank selection only affects the bottom group; upper groups stay bank 0
    wire in_exp_grp;
    wire exp_hit_f;
    wire exp_unimpl;
    assign in_exp_grp = (eff_addr[7:4] == `BRF_GRP_F) && (bank_sel != `BRF_BANK0);
    assign exp_hit_f = in_exp_grp && (bank_sel == `BRF_BANKF) &&
        (eff_addr[3:0] == `BRF_F_PORT_CFG || eff_addr[3:0] == `BRF_F_STOP_RCV ||
         eff_addr[3:0] == `BRF_F_STOP_RCV2 || eff_addr[3:0] == `BRF_F_WDOG);
    assign exp_unimpl = in_exp_grp && !exp_hit_f;

    wire is_ctl;
    wire is_port;
    wire is_gpr;
    assign is_ctl = !in_exp_grp && (eff_addr >= `BRF_ADDR_CTL_LO) &&
        (eff_addr != `BRF_ADDR_SP_HI);
    assign is_port = !in_exp_grp && (eff_addr <= `BRF_ADDR_P3) &&
        (eff_addr != `BRF_ADDR_P1);
    assign is_gpr = !in_exp_grp && !is_ctl && !is_port;

    wire prot_range;
    assign prot_range = (eff_addr >= `BRF_ADDR_PROT_LO) && (eff_addr <= `BRF_ADDR_PROT_HI);

    wire wr_go;
    wire gpr_wr;
    assign wr_go = acc_en && acc_wr && !direct_blocked;
    assign gpr_wr = wr_go && is_gpr &&
        !((RAM_PROT_OPT != 0) && ram_protect_on && prot_range);

    // ------------------------------------------------------------
    // general-purpose storage (also backs the stack and the high pointer)
    // ------------------------------------------------------------
    // the high pointer is plain storage, so every reset clears it by a write into the array
    wire store_wr;
    wire [7:0] store_waddr;
    wire [7:0] store_wdata;
    wire [7:0] gpr_rdata;
    assign store_wr = gpr_wr || dev_rst;
    assign store_waddr = dev_rst ? `BRF_ADDR_SP_HI : eff_addr;
    assign store_wdata = dev_rst ? `BRF_SP_RST : acc_wdata;
    brf_gpr_bank u_gpr (
        .core_clk(core_clk),
        .wr_en(store_wr),
        .wr_addr(store_waddr),
        .wr_data(store_wdata),
        .rd_addr(eff_addr),
        .rd_data(gpr_rdata)
    );

    // ------------------------------------------------------------
    // control register next values
    // ------------------------------------------------------------
    reg [7:0] int_mask_r;
    reg [7:0] int_mask_nxt;
    reg [7:0] ptr_nxt;
    reg [7:0] sp_low_nxt;
    reg prot_nxt;
    wire ctl_wr;
    assign ctl_wr = wr_go && is_ctl;

    always @* begin
        ptr_nxt = register_group_bank_pointer;
        sp_low_nxt = stack_pointer_low;
        int_mask_nxt = int_mask_r;
        prot_nxt = ram_protect_on;
        if (ctl_wr) begin
            case (eff_addr)
                `BRF_ADDR_PTR: begin
                    ptr_nxt = acc_wdata;
                end
                `BRF_ADDR_SP_LO: begin
                    sp_low_nxt = acc_wdata;
                end
                `BRF_ADDR_INT_MASK: begin
                    int_mask_nxt = acc_wdata;
                    // without the option built in the flag can never rise
                    prot_nxt = (RAM_PROT_OPT != 0) && acc_wdata[`BRF_MASK_PROT_BIT];
                end
                default: begin
                    ptr_nxt = register_group_bank_pointer;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (dev_rst) begin
            register_group_bank_pointer <= `BRF_PTR_RST;
            stack_pointer_low <= `BRF_SP_RST;
            int_mask_r <= `BRF_MASK_RST;
            ram_protect_on <= 1'b0;
        end else begin
            register_group_bank_pointer <= ptr_nxt;
            stack_pointer_low <= sp_low_nxt;
            int_mask_r <= int_mask_nxt;
            ram_protect_on <= prot_nxt;
        end
    end

    // ------------------------------------------------------------
    // bank f configuration registers
    // ------------------------------------------------------------
    reg [7:0] port_cfg_nxt;
    reg [7:0] stop_rcv_nxt;
    reg [7:0] stop_rcv_two_nxt;
    reg [7:0] wdog_nxt;
    wire cfg_wr;
    assign cfg_wr = wr_go && exp_hit_f;

    always @* begin
        port_cfg_nxt = port_configuration_reg;
        stop_rcv_nxt = stop_recovery_reg;
        stop_rcv_two_nxt = stop_recovery_reg_two;
        wdog_nxt = watchdog_mode_reg;
        if (cfg_wr) begin
            case (eff_addr[3:0])
                `BRF_F_PORT_CFG: begin
                    port_cfg_nxt = acc_wdata;
                end
                `BRF_F_STOP_RCV: begin
                    stop_rcv_nxt = acc_wdata;
                end
                `BRF_F_STOP_RCV2: begin
                    stop_rcv_two_nxt = acc_wdata;
                end
                `BRF_F_WDOG: begin
                    wdog_nxt = acc_wdata;
                end
                default: begin
                    wdog_nxt = watchdog_mode_reg;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (dev_rst) begin
            port_configuration_reg <= `BRF_PORT_CFG_RST;
            stop_recovery_reg <= `BRF_STOP_RCV_RST;
            stop_recovery_reg_two <= `BRF_STOP_RCV2_RST;
            watchdog_mode_reg <= `BRF_WDOG_RST;
        end else begin
            port_configuration_reg <= port_cfg_nxt;
            stop_recovery_reg <= stop_rcv_nxt;
            stop_recovery_reg_two <= stop_rcv_two_nxt;
            watchdog_mode_reg <= wdog_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    reg [7:0] ctl_rd;
    reg [7:0] rdata_nxt;
    wire rd_go;
    assign rd_go = acc_en && !acc_wr;

    always @* begin
        case (eff_addr)
            `BRF_ADDR_PTR: ctl_rd = register_group_bank_pointer;
            `BRF_ADDR_SP_LO: ctl_rd = stack_pointer_low;
            `BRF_ADDR_INT_MASK: ctl_rd = int_mask_r;
            default: ctl_rd = `BRF_UNDEF_RD;
        endcase
    end

    // data holds until the next read, so the core may pick it up late
    always @* begin
        rdata_nxt = acc_rdata;
        if (rd_go) begin
            if (direct_blocked) begin
                rdata_nxt = `BRF_UNDEF_RD;
            end else if (exp_unimpl) begin
                rdata_nxt = `BRF_UNDEF_RD;
            end else if (exp_hit_f) begin
                // bank f registers are write only
                rdata_nxt = `BRF_UNDEF_RD;
            end else if (is_port) begin
                rdata_nxt = port_rdata;
            end else if (is_ctl) begin
                rdata_nxt = ctl_rd;
            end else begin
                rdata_nxt = gpr_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // port strobes and read handshake
    // ------------------------------------------------------------
    reg [7:0] port_wdata_nxt;
    reg [1:0] port_sel_nxt;
    reg port_wr_nxt;
    always @* begin
        port_wr_nxt = wr_go && is_port;
        port_wdata_nxt = port_wdata;
        port_sel_nxt = port_sel;
        if (port_wr_nxt) begin
            port_wdata_nxt = acc_wdata;
            port_sel_nxt = eff_addr[1:0];
        end
    end

    always @(posedge core_clk) begin
        if (dev_rst) begin
            acc_rdata <= `BRF_OUT_RST;
            acc_rvalid <= 1'b0;
            port_wr <= 1'b0;
            port_wdata <= `BRF_OUT_RST;
            port_sel <= `BRF_SEL_RST;
        end else begin
            acc_rdata <= rdata_nxt;
            acc_rvalid <= rd_go;
            port_wr <= port_wr_nxt;
            port_wdata <= port_wdata_nxt;
            port_sel <= port_sel_nxt;
        end
    end

    // ------------------------------------------------------------
    // low voltage flag
    // ------------------------------------------------------------
    // a low voltage event wins over a clear in the same cycle so it is never lost
    reg suspect_nxt;
    wire suspect_clr;
    assign suspect_clr = !resetn || por_rst;
    always @* begin
        suspect_nxt = gpr_suspect;
        if (lv_rst) begin
            suspect_nxt = 1'b1;
        end else if (suspect_clr) begin
            suspect_nxt = 1'b0;
        end
    end
    always @(posedge core_clk) begin
        gpr_suspect <= suspect_nxt;
    end
endmodule

// *** brf_defs.vh ***
// constants for the banked register file and its addressing
`ifndef BRF_DEFS_VH
`define BRF_DEFS_VH
// ------------------------------------------------------------
// register addresses (bank 0 unless stated)
// ------------------------------------------------------------
`define BRF_ADDR_PTR 8'hfd
`define BRF_ADDR_SP_HI 8'hfe
`define BRF_ADDR_SP_LO 8'hff
`define BRF_ADDR_INT_MASK 8'hfb
`define BRF_ADDR_P0 8'h00
`define BRF_ADDR_P1 8'h01
`define BRF_ADDR_P3 8'h03
`define BRF_ADDR_CTL_LO 8'hf0
`define BRF_ADDR_PROT_LO 8'h80
`define BRF_ADDR_PROT_HI 8'hef
`define BRF_WR_HI_NIB 4'he
`define BRF_BANK0 4'h0
`define BRF_BANKF 4'hf
// bank f locations
`define BRF_F_PORT_CFG 4'h0
`define BRF_F_STOP_RCV 4'hb
`define BRF_F_STOP_RCV2 4'hd
`define BRF_F_WDOG 4'hf
`define BRF_GRP_F 4'h0
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define BRF_PTR_GRP_HI 7
`define BRF_PTR_GRP_LO 4
`define BRF_PTR_BANK_HI 3
`define BRF_PTR_BANK_LO 0
`define BRF_MASK_PROT_BIT 6
`define BRF_PTR_RST 8'h00
`define BRF_SP_RST 8'h00
`define BRF_PORT_CFG_RST 8'hfe
`define BRF_STOP_RCV_RST 8'h20
`define BRF_STOP_RCV2_RST 8'h00
`define BRF_WDOG_RST 8'h0f
`define BRF_MASK_RST 8'h00
`define BRF_OUT_RST 8'h00
`define BRF_SEL_RST 2'h0
`define BRF_UNDEF_RD 8'hff
// addressing modes presented by the core
`define BRF_MODE_DIRECT 2'h0
`define BRF_MODE_WORK 2'h1
`define BRF_MODE_INDIR 2'h2
`endif

// *** brf_gpr_bank.v ***
// general-purpose storage, deliberately without reset so contents survive resets
`include "brf_defs.vh"
module brf_gpr_bank (
    input wire core_clk,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem_r [0:255];
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset: values held across resets, undefined at power up
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end
    // read is combinational so storage answers in the same cycle as the control registers
    always @* begin
        rd_data = mem_r[rd_addr];
    end
endmodule

// *** brf_reg_file_monitor.sv ***
// checker watching the ports of the banked register file
module brf_reg_file_monitor #(
    parameter RAM_PROT_OPT = 1
) (
    input wire core_clk, resetn, por_rst, wdt_rst, stop_rcv_rst, lv_rst, acc_en, acc_wr,
    input wire [1:0] acc_mode,
    input wire [7:0] acc_addr, acc_wdata, port_rdata, acc_rdata,
    input wire acc_rvalid, port_wr, ram_protect_on, gpr_suspect,
    input wire [7:0] port_wdata,
    input wire [1:0] port_sel,
    input wire [7:0] register_group_bank_pointer, stack_pointer_low, port_configuration_reg,
    input wire [7:0] stop_recovery_reg, stop_recovery_reg_two, watchdog_mode_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    wire side_rst = por_rst || wdt_rst || stop_rcv_rst || lv_rst;
    wire rst_any = !resetn || side_rst;
    wire rd = acc_en && !acc_wr;
    wire dwr = acc_en && acc_wr && acc_mode == 2'h0 && !rst_any;
    wire [3:0] bank = register_group_bank_pointer[3:0];
    default clocking mon_cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    AST_RVALID: assert property (rd && !rst_any |=> acc_rvalid)
        else $error("read strobe missing");
    AST_NO_RVALID: assert property (!rd |=> !acc_rvalid)
        else $error("stray read strobe");
    AST_PTR_WR: assert property (
        dwr && acc_addr == 8'hfd |=> register_group_bank_pointer == $past(acc_wdata))
        else $error("pointer write lost");
    AST_PTR_HOLD: assert property (
        !(acc_en && acc_wr) && !rst_any |=> $stable(register_group_bank_pointer))
        else $error("pointer changed without a write");
    AST_SP_RST: assert property (
        side_rst |=> register_group_bank_pointer == 8'h00 && stack_pointer_low == 8'h00)
        else $error("pointers not cleared by reset");
    AST_REL: assert property (
        $rose(resetn) |-> port_configuration_reg == 8'hfe && stop_recovery_reg == 8'h20
        && stop_recovery_reg_two == 8'h00 && watchdog_mode_reg == 8'h0f && !ram_protect_on)
        else $error("reset values wrong");
    AST_PROT: assert property (
        dwr && acc_addr == 8'hfb |=> ram_protect_on == (RAM_PROT_OPT != 0 && $past(acc_wdata[6])))
        else $error("protect flag wrong");
    AST_PORT: assert property (
        dwr && bank == 4'h0 && acc_addr == 8'h02
        |=> port_wr && port_sel == 2'h2 && port_wdata == $past(acc_wdata))
        else $error("port write wrong");
    AST_WDT: assert property (
        dwr && bank == 4'hf && acc_addr == 8'h0f |=> watchdog_mode_reg == $past(acc_wdata))
        else $error("bank f write lost");
    AST_LV: assert property (lv_rst |=> gpr_suspect)
        else $error("suspect flag not set");
    AST_E0: assert property (
        rd && acc_mode == 2'h0 && acc_addr[7:4] == 4'he && !rst_any ##1 !rd && !rst_any
        |-> ##1 acc_rdata == 8'hff)
        else $error("direct access to e0 to ef not refused");
endmodule

// *** brf_core_model.sv ***
// core-side access model issuing register accesses
module brf_core_model (
    input wire core_clk,
    input wire acc_rvalid,
    input wire [7:0] acc_rdata,
    output logic acc_en,
    output logic acc_wr,
    output logic [1:0] acc_mode,
    output logic [7:0] acc_addr,
    output logic [7:0] acc_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        acc_en = 1'b0;
        acc_wr = 1'b0;
        acc_mode = 2'h0;
        acc_addr = 8'h00;
        acc_wdata = 8'h00;
    end
    // released fields are inverted so nothing can lean on stale values
    task automatic xfer(input logic w, input logic [1:0] m, input logic [7:0] a,
                        input logic [7:0] x, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        acc_en = 1'b1;
        acc_wr = w;
        acc_mode = m;
        acc_addr = a;
        acc_wdata = x;
        @(posedge core_clk);
        #1;
        acc_en = 1'b0;
        acc_addr = ~a;
        acc_wdata = ~x;
        r = 8'h00;
        if (!w) begin
            // the strobe stands one cycle: take the answer at the edge that sees the strobe high
            @(posedge core_clk);
            while (acc_rvalid !== 1'b1 && n < 4) begin
                @(posedge core_clk);
                n++;
            end
            r = acc_rdata;
        end
    endtask
endmodule

// *** brf_tb.sv ***
// self-checking bench for the banked register file
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam RAM_PROT_OPT = 1;
    logic core_clk, resetn, por_rst, wdt_rst, stop_rcv_rst, lv_rst, acc_en, acc_wr;
    logic acc_rvalid, port_wr, ram_protect_on, gpr_suspect;
    logic [1:0] acc_mode, port_sel;
    logic [7:0] acc_addr, acc_wdata, port_rdata, acc_rdata, port_wdata;
    logic [7:0] register_group_bank_pointer, stack_pointer_low, port_configuration_reg;
    logic [7:0] stop_recovery_reg, stop_recovery_reg_two, watchdog_mode_reg, d, g, p;
    int failures = 0, total_checks = 0, cycles = 0;
    brf_reg_file #(.RAM_PROT_OPT(RAM_PROT_OPT)) brf_reg_file_inst (.*);
    brf_core_model brf_core_model_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            summarize();
        end
    end
    function automatic logic [7:0] work_addr(input logic [7:0] ptr, input logic [7:0] a);
        return {ptr[7:4], a[3:0]};
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] m, input logic [7:0] a, input logic [7:0] x);
        logic [7:0] r;
        brf_core_model_inst.xfer(1'b1, m, a, x, r);
    endtask
    task automatic rdchk(input string name, input logic [1:0] m, input logic [7:0] a,
                         input logic [7:0] exp);
        logic [7:0] r;
        brf_core_model_inst.xfer(1'b0, m, a, 8'h00, r);
        chk(name, exp, r);
    endtask
    task automatic pulse(ref logic s);
        @(posedge core_clk);
        #1 s = 1'b1;
        @(posedge core_clk);
        #1 s = 1'b0;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {resetn, por_rst, wdt_rst, stop_rcv_rst, lv_rst} = 5'h00;
        port_rdata = 8'h00;
        void'($urandom(32'h5a51));
        repeat (8) @(posedge core_clk);
        #1 resetn = 1'b1;
        chk("port_cfg", 8'hfe, port_configuration_reg);
        chk("wdog_mode", 8'h0f, watchdog_mode_reg);
        chk("sp_low", 8'h00, stack_pointer_low);
        done("reset");
        for (int i = 0; i < 6; i++) begin
            g = 8'($urandom % 13 + 1);
            d = 8'($urandom);
            p = {g[3:0], d[7:4]};
            wr(2'h0, 8'hfd, p);
            rdchk("pointer", 2'h0, 8'hfd, p);
            wr(2'h1, d, d);
            rdchk("work", 2'h0, work_addr(p, d), d);
            rdchk("indirect", 2'h2, work_addr(p, d), d);
        end
        done("mapping");
        wr(2'h0, 8'hfd, 8'he0);
        wr(2'h1, 8'h07, 8'h5a);
        rdchk("direct_e", 2'h0, 8'he7, 8'hff);
        rdchk("indir_e", 2'h2, 8'he7, 8'h5a);
        done("window");
        wr(2'h0, 8'h90, 8'h11);
        wr(2'h0, 8'hfb, 8'h40);
        wr(2'h0, 8'h90, 8'h22);
        rdchk("prot", 2'h0, 8'h90, 8'h11);
        wr(2'h0, 8'hfb, 8'h00);
        wr(2'h0, 8'h90, 8'h22);
        rdchk("unprot", 2'h0, 8'h90, 8'h22);
        done("protect");
        wr(2'h0, 8'hff, 8'h3c);
        rdchk("sp_low_rd", 2'h0, 8'hff, 8'h3c);
        wr(2'h0, 8'hfe, 8'h77);
        rdchk("sp_high", 2'h0, 8'hfe, 8'h77);
        wr(2'h0, 8'h40, 8'ha5);
        pulse(stop_rcv_rst);
        chk("sp_low_rst", 8'h00, stack_pointer_low);
        rdchk("sp_high_rst", 2'h0, 8'hfe, 8'h00);
        pulse(wdt_rst);
        pulse(por_rst);
        @(posedge core_clk);
        #1 resetn = 1'b0;
        @(posedge core_clk);
        #1 resetn = 1'b1;
        chk("ptr_rst", 8'h00, register_group_bank_pointer);
        rdchk("retain", 2'h0, 8'h40, 8'ha5);
        pulse(lv_rst);
        chk("suspect", 8'h01, {7'h00, gpr_suspect});
        done("retention");
        d = 8'($urandom);
        wr(2'h0, 8'hfd, 8'h0f);
        wr(2'h0, 8'h0f, d);
        chk("wdog_wr", d, watchdog_mode_reg);
        rdchk("wdog_rd", 2'h0, 8'h0f, 8'hff);
        wr(2'h0, 8'hfd, 8'h05);
        wr(2'h0, 8'h03, d);
        rdchk("unimpl", 2'h0, 8'h03, 8'hff);
        wr(2'h0, 8'hfd, 8'h00);
        port_rdata = 8'($urandom);
        wr(2'h0, 8'h02, d);
        rdchk("port", 2'h0, 8'h03, port_rdata);
        done("banks");
        summarize();
    end
endmodule
bind brf_reg_file brf_reg_file_monitor #(.RAM_PROT_OPT(RAM_PROT_OPT)) brf_reg_file_monitor_inst (.*);
